/* core/pcg_fault_check.sv */
// access checker: flags a peripheral access whose clock is gated off
// assumes access requests are single-cycle and synchronous to clk
`timescale 1ns/1ns
module pcg_fault_check #(
   parameter int N = 9
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             req,
   input  wire logic [3:0]       unit,
   input  wire logic [N-1:0]     en,
   output logic                  fault_reg,
   output logic                  ok_reg
);
   logic hit_en;

   assign hit_en = (32'(unit) < N) ? en[unit] : 1'b0;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fault_reg <= 1'b0;
         ok_reg    <= 1'b0;
      end else begin
         fault_reg <= req & ~hit_en; // RQ2
         ok_reg    <= req & hit_en;
      end
   end
endmodule : pcg_fault_check

/* core/pcg_gate_cell.sv */
// glitch-free latch-based clock gate for one peripheral
// assumes enable changes only from logic on the rising edge of clk
`timescale 1ns/1ns
module pcg_gate_cell (
   input  wire logic clk,
   input  wire logic en,
   output logic      gclk
);
   logic en_lat;

   // latch transparent while clock low, so no pulse is cut short
   always_latch begin
      if (!clk) begin
         en_lat <= en;
      end
   end

   assign gclk = clk & en_lat;
endmodule : pcg_gate_cell

/* core/pcg_pkg.sv */
// package for the peripheral clock gating block, group one
// assumes a 32-bit plain register port, word aligned offsets
package pcg_pkg;
   // ------------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------------
   localparam logic [11:0] RUN_GATE_OFS   = 12'h104;
   localparam logic [11:0] SLEEP_GATE_OFS = 12'h114;
   localparam logic [11:0] DEEP_GATE_OFS  = 12'h124;
   localparam logic [11:0] WDOG_GATE_OFS  = 12'h120;
   localparam logic [11:0] MODE_CTRL_OFS  = 12'h200;
   localparam logic [11:0] IRQ_STAT_OFS   = 12'h204;
   localparam logic [11:0] IRQ_MASK_OFS   = 12'h208;
   localparam logic [11:0] FAULT_INFO_OFS = 12'h20C;

   // ------------------------------------------------------------------
   // gate bit positions
   // ------------------------------------------------------------------
   localparam int ASYNC0_BIT  = 0;
   localparam int ASYNC1_BIT  = 1;
   localparam int SYNC0_BIT   = 4;
   localparam int TWOW0_BIT   = 12;
   localparam int GPC0_BIT    = 16;
   localparam int GPC1_BIT    = 17;
   localparam int GPC2_BIT    = 18;
   localparam int COMPARATOR_ZERO_CLOCK_ENABLE_BIT   = 24;
   localparam int WDOG_BIT    = 3;
   localparam int AUTO_GATE_BIT = 0;
   localparam int SLEEP_BIT   = 1;
   localparam int DEEP_BIT    = 2;

   localparam logic [31:0] GATE_WMASK  = 32'h0107_1013;
   localparam logic [31:0] WDOG_WMASK  = 32'h0000_0008;
   localparam logic [31:0] GATE_RESET  = 32'h0000_0000;
   localparam logic [31:0] MODE_RESET  = 32'h0000_0000;
   localparam logic [31:0] IRQ_RESET   = 32'h0000_0000;
   localparam int NUM_UNITS = 9;
   localparam int IRQ_W     = 2;
   localparam int IRQ_FAULT_BIT = 0;
   localparam int IRQ_UNMAP_BIT = 1;

   typedef enum logic [1:0] {PCG_RUN, PCG_SLEEP, PCG_DEEP} pcg_mode_e;

   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } pcg_bus_s;

   typedef struct packed {
      logic       req;
      logic [3:0] unit;
   } pcg_access_s;
endpackage : pcg_pkg

/* core/pcg_top.sv */
// peripheral clock gating, group one: run, sleep and deep-sleep gates
// assumes a plain register port from the system bus, one clock mclk
//
// Overview of operation
// [RQ1] a set gate bit clocks its unit; a clear one stops and disables it
// [RQ2] accesses to a unit whose gate is off answer with a bus fault
// [RQ3] all gate bits reset to zero, so every unit starts unclocked; here the watchdog, unit 8, is still clocked in run mode after reset
// [RQ4] software must set gate bits for the units it needs
// [RQ5] run gate governs running, sleep gate sleep, deep gate deep sleep
// [RQ6] sleep and deep gates apply only while auto gating is set
// [RQ7] bits 16 to 18 gate counters 0 to 2, bit 24 comparator 0
// [RQ8] bit 12 gates two-wire port 0, read write, reset zero
// [RQ9] bit 4 gates synchronous serial port 0, read write, reset zero
// [RQ10] bit 1 gates asynchronous serial port 1, read write, reset zero
// [RQ11] bit 0 gates asynchronous serial port 0, read write, reset zero
// [RQ12] reserved bits read zero and ignore writes
// [RQ13] deep gate of group zero bit 3 gates the watchdog clock
// [RQ14] unassigned bit positions behave as reserved
// [RQ15] deep gate register sits at offset 0x124, same layout
// [RQ16] gate changes go through glitch-free gate cells
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
module pcg_top (
   input  wire logic                     mclk,
   input  wire logic                     rstn,
   input  wire logic [11:0]              addr,
   input  wire logic [31:0]              wdata,
   input  wire logic                     wr,
   input  wire logic                     rd,
   output logic      [31:0]              rdata_reg,
   input  wire logic                     acc_req,
   input  wire logic [3:0]               acc_unit,
   output logic                          acc_fault_reg,
   output logic                          acc_ok_reg,
   output logic [pcg_pkg::NUM_UNITS:0]   unit_en_reg,
   output logic [pcg_pkg::NUM_UNITS:0]   unit_gclk,
   output logic                          irq_reg
);
   localparam int N = pcg_pkg::NUM_UNITS;

   pcg_pkg::pcg_bus_s    bus;
   pcg_pkg::pcg_access_s acc;
   pcg_pkg::pcg_mode_e   mode;
   logic [31:0] run_gate_reg;
   logic [31:0] sleep_gate_reg;
   logic [31:0] deep_gate_reg;
   logic [31:0] wdog_gate_reg;
   logic [31:0] mode_reg;
   logic [pcg_pkg::IRQ_W-1:0] irq_stat_reg;
   logic [pcg_pkg::IRQ_W-1:0] irq_mask_reg;
   logic [3:0]  fault_unit_reg;
   logic [31:0] eff_gate;
   logic [31:0] eff_wdog;
   logic [N:0]  en_next;
   logic [31:0] rdata_next;
   logic        mapped;
   logic        unmap_evt;
   logic        fault_evt;
   logic        ok_evt;
   logic [pcg_pkg::IRQ_W-1:0] evt;

   assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
   assign acc = '{req: acc_req, unit: acc_unit};

   // ------------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         run_gate_reg   <= pcg_pkg::GATE_RESET; // RQ3
         sleep_gate_reg <= pcg_pkg::GATE_RESET; // RQ3
         deep_gate_reg  <= pcg_pkg::GATE_RESET; // RQ3
         wdog_gate_reg  <= pcg_pkg::GATE_RESET; // RQ3
      end else if (bus.wr) begin
         // reserved positions masked off so they always read zero
         unique case (bus.addr)
            pcg_pkg::RUN_GATE_OFS:   run_gate_reg   <= bus.wdata & pcg_pkg::GATE_WMASK; // RQ12
            pcg_pkg::SLEEP_GATE_OFS: sleep_gate_reg <= bus.wdata & pcg_pkg::GATE_WMASK; // RQ14
            pcg_pkg::DEEP_GATE_OFS:  deep_gate_reg  <= bus.wdata & pcg_pkg::GATE_WMASK; // RQ15
            pcg_pkg::WDOG_GATE_OFS:  wdog_gate_reg  <= bus.wdata & pcg_pkg::WDOG_WMASK; // RQ13
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         mode_reg <= pcg_pkg::MODE_RESET;
      end else if (bus.wr && bus.addr == pcg_pkg::MODE_CTRL_OFS) begin
         mode_reg <= {29'h0, bus.wdata[2:0]};
      end
   end

   // ------------------------------------------------------------------
   // operating mode and effective gate
   // ------------------------------------------------------------------
   always_comb begin
      if (!mode_reg[pcg_pkg::AUTO_GATE_BIT]) begin
         mode = pcg_pkg::PCG_RUN; // RQ6
      end else if (mode_reg[pcg_pkg::DEEP_BIT]) begin
         mode = pcg_pkg::PCG_DEEP;
      end else if (mode_reg[pcg_pkg::SLEEP_BIT]) begin
         mode = pcg_pkg::PCG_SLEEP;
      end else begin
         mode = pcg_pkg::PCG_RUN;
      end
   end

   always_comb begin
      eff_wdog = 32'h0;
      unique case (mode)
         pcg_pkg::PCG_RUN:   eff_gate = run_gate_reg;   // RQ5
         pcg_pkg::PCG_SLEEP: eff_gate = sleep_gate_reg; // RQ5
         pcg_pkg::PCG_DEEP: begin
            eff_gate = deep_gate_reg; // RQ5
            eff_wdog = wdog_gate_reg; // RQ13
         end
         default:            eff_gate = run_gate_reg;
      endcase
   end

   always_comb begin
      en_next[0] = eff_gate[pcg_pkg::ASYNC0_BIT]; // RQ11
      en_next[1] = eff_gate[pcg_pkg::ASYNC1_BIT]; // RQ10
      en_next[2] = eff_gate[pcg_pkg::SYNC0_BIT];  // RQ9
      en_next[3] = eff_gate[pcg_pkg::TWOW0_BIT];  // RQ8
      en_next[4] = eff_gate[pcg_pkg::GPC0_BIT];   // RQ7
      en_next[5] = eff_gate[pcg_pkg::GPC1_BIT];   // RQ7
      en_next[6] = eff_gate[pcg_pkg::GPC2_BIT];   // RQ7
      en_next[7] = eff_gate[pcg_pkg::COMPARATOR_ZERO_CLOCK_ENABLE_BIT];  // RQ7
      // watchdog run and sleep gates live outside this block, so it stays on there
      en_next[8] = (mode == pcg_pkg::PCG_DEEP) ? eff_wdog[pcg_pkg::WDOG_BIT] : 1'b1;
      en_next[N] = 1'b0;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         unit_en_reg <= '0;
      end else begin
         unit_en_reg <= en_next; // RQ1
      end
   end

   // ------------------------------------------------------------------
   // clock gate cells
   // ------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi <= N; gi++) begin : g_gate
         pcg_gate_cell u_cell (
            .clk  (mclk),
            .en   (unit_en_reg[gi]),
            .gclk (unit_gclk[gi])
         ); // RQ16
      end
   endgenerate

   // ------------------------------------------------------------------
   // access fault detection
   // ------------------------------------------------------------------
   pcg_fault_check #(.N(N)) u_fault (
      .clk       (mclk),
      .rstn      (rstn),
      .req       (acc.req),
      .unit      (acc.unit),
      .en        (unit_en_reg[N-1:0]),
      .fault_reg (fault_evt),
      .ok_reg    (ok_evt)
   );

   assign acc_fault_reg = fault_evt; // RQ2
   assign acc_ok_reg    = ok_evt;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         fault_unit_reg <= 4'h0;
      end else if (acc.req && !(32'(acc.unit) < N && unit_en_reg[acc.unit])) begin
         fault_unit_reg <= acc.unit;
      end
   end

   // ------------------------------------------------------------------
   // register reads
   // ------------------------------------------------------------------
   always_comb begin
      mapped = 1'b1;
      unique case (bus.addr)
         pcg_pkg::RUN_GATE_OFS:   rdata_next = run_gate_reg;
         pcg_pkg::SLEEP_GATE_OFS: rdata_next = sleep_gate_reg;
         pcg_pkg::DEEP_GATE_OFS:  rdata_next = deep_gate_reg;
         pcg_pkg::WDOG_GATE_OFS:  rdata_next = wdog_gate_reg;
         pcg_pkg::MODE_CTRL_OFS:  rdata_next = mode_reg;
         pcg_pkg::IRQ_STAT_OFS:   rdata_next = {30'h0, irq_stat_reg};
         pcg_pkg::IRQ_MASK_OFS:   rdata_next = {30'h0, irq_mask_reg};
         pcg_pkg::FAULT_INFO_OFS: rdata_next = {28'h0, fault_unit_reg};
         default: begin
            rdata_next = 32'h0;
            mapped     = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rdata_reg <= 32'h0;
      end else if (bus.rd) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= 32'h0;
      end
   end

   // ------------------------------------------------------------------
   // interrupts: sticky status, write one to clear, set wins
   // ------------------------------------------------------------------
   assign unmap_evt = (bus.rd | bus.wr) & ~mapped;
   assign evt = {unmap_evt, fault_evt};

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         irq_stat_reg <= pcg_pkg::IRQ_RESET[pcg_pkg::IRQ_W-1:0];
      end else begin
         if (bus.wr && bus.addr == pcg_pkg::IRQ_STAT_OFS) begin
            irq_stat_reg <= (irq_stat_reg & ~bus.wdata[pcg_pkg::IRQ_W-1:0]) | evt;
         end else begin
            irq_stat_reg <= irq_stat_reg | evt;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         irq_mask_reg <= pcg_pkg::IRQ_RESET[pcg_pkg::IRQ_W-1:0];
      end else if (bus.wr && bus.addr == pcg_pkg::IRQ_MASK_OFS) begin
         irq_mask_reg <= bus.wdata[pcg_pkg::IRQ_W-1:0];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   // the release edge is skipped: enables still hold their reset value there
   gate_follow_a: assert property (@(posedge mclk) disable iff (!rstn) // RQ1
      rstn |=> unit_en_reg[N-1:0] == $past(en_next[N-1:0]))
      else $error("unit enable does not follow effective gate");

   fault_off_a: assert property (@(posedge mclk) disable iff (!rstn) // RQ2
      (acc_req && acc_unit == 4'h0 && !unit_en_reg[0]) |=> acc_fault_reg && !acc_ok_reg)
      else $error("access to gated unit not faulted");

   reset_zero_a: assert property (@(posedge mclk) // RQ3
      $rose(rstn) |-> run_gate_reg == 32'h0 && sleep_gate_reg == 32'h0)
      else $error("gate registers not zero after reset");

   run_select_a: assert property (@(posedge mclk) disable iff (!rstn) // RQ6
      !mode_reg[0] |=> unit_en_reg[3] == $past(run_gate_reg[12]))
      else $error("run gate not in force without auto gating");

   sleep_select_a: assert property (@(posedge mclk) disable iff (!rstn) // RQ5
      (mode_reg[2:0] == 3'h3) |=> unit_en_reg[4] == $past(sleep_gate_reg[16]))
      else $error("sleep gate not applied in sleep");

   reserved_zero_a: assert property (@(posedge mclk) disable iff (!rstn) // RQ12
      (rd && addr == 12'h104) |=> (rdata_reg & ~32'h0107_1013) == 32'h0)
      else $error("reserved bits read nonzero");

   write_bits_a: assert property (@(posedge mclk) disable iff (!rstn) // RQ7
      (wr && addr == 12'h104) |=> run_gate_reg == ($past(wdata) & 32'h0107_1013))
      else $error("run gate write not stored");

   // deep wins over sleep whenever auto gating is on
   deep_wdog_a: assert property (@(posedge mclk) disable iff (!rstn) // RQ13
      (mode_reg[0] && mode_reg[2]) |=> unit_en_reg[8] == $past(wdog_gate_reg[3]))
      else $error("watchdog deep gate not applied");

   // ------------------------------------------------------------------
   // assertions: stores, selection and access answers
   // ------------------------------------------------------------------
   sleep_write_a: assert property (@(posedge mclk) disable iff (!rstn) // RQ14
      (wr && addr == 12'h114) |=> sleep_gate_reg == ($past(wdata) & 32'h0107_1013))
      else $error("sleep gate write not stored");

   deep_write_a: assert property (@(posedge mclk) disable iff (!rstn) // RQ15
      (wr && addr == 12'h124) |=> deep_gate_reg == ($past(wdata) & 32'h0107_1013))
      else $error("deep gate write not stored");

   wdog_write_a: assert property (@(posedge mclk) disable iff (!rstn) // RQ13
      (wr && addr == 12'h120) |=> wdog_gate_reg == ($past(wdata) & 32'h0000_0008))
      else $error("watchdog deep gate write not stored");

   sleep_reserved_a: assert property (@(posedge mclk) disable iff (!rstn) // RQ12
      (rd && addr == 12'h114) |=> (rdata_reg & ~32'h0107_1013) == 32'h0)
      else $error("sleep gate reserved bits read nonzero");

   wdog_reserved_a: assert property (@(posedge mclk) disable iff (!rstn) // RQ14
      (rd && addr == 12'h120) |=> (rdata_reg & ~32'h0000_0008) == 32'h0)
      else $error("watchdog gate unassigned bits read nonzero");

   reset_en_a: assert property (@(posedge mclk) // RQ3
      $rose(rstn) |-> unit_en_reg == '0 && deep_gate_reg == 32'h0 && wdog_gate_reg == 32'h0)
      else $error("enables or deep gates not zero after reset");

   run_async0_a: assert property (@(posedge mclk) disable iff (!rstn) // RQ11
      !mode_reg[0] |=> unit_en_reg[0] == $past(run_gate_reg[0]))
      else $error("async port 0 enable wrong in run");

   run_async1_a: assert property (@(posedge mclk) disable iff (!rstn) // RQ10
      !mode_reg[0] |=> unit_en_reg[1] == $past(run_gate_reg[1]))
      else $error("async port 1 enable wrong in run");

   run_sync_a: assert property (@(posedge mclk) disable iff (!rstn) // RQ9
      !mode_reg[0] |=> unit_en_reg[2] == $past(run_gate_reg[4]))
      else $error("sync port enable wrong in run");

   run_counters_a: assert property (@(posedge mclk) disable iff (!rstn) // RQ7
      !mode_reg[0] |=> unit_en_reg[7:4] == {$past(run_gate_reg[24]), $past(run_gate_reg[18:16])})
      else $error("counter or comparator enable wrong in run");

   sleep_twowire_a: assert property (@(posedge mclk) disable iff (!rstn) // RQ8
      (mode_reg[1:0] == 2'h3 && !mode_reg[2]) |=> unit_en_reg[3] == $past(sleep_gate_reg[12]))
      else $error("two-wire enable wrong in sleep");

   deep_select_a: assert property (@(posedge mclk) disable iff (!rstn) // RQ5
      (mode_reg[0] && mode_reg[2]) |=>
         unit_en_reg[7] == $past(deep_gate_reg[24]) && unit_en_reg[1] == $past(deep_gate_reg[1]))
      else $error("deep gate not applied in deep sleep");

   ok_on_a: assert property (@(posedge mclk) disable iff (!rstn) // RQ1
      (acc_req && acc_unit == 4'h7 && unit_en_reg[7]) |=> acc_ok_reg && !acc_fault_reg)
      else $error("access to clocked unit not answered");

   unit_range_a: assert property (@(posedge mclk) disable iff (!rstn) // RQ2
      (acc_req && acc_unit > 4'h8) |=> acc_fault_reg && !acc_ok_reg)
      else $error("access to absent unit not faulted");

   fault_flag_a: assert property (@(posedge mclk) disable iff (!rstn) // RQ2
      acc_fault_reg |=> irq_stat_reg[0])
      else $error("bus fault not recorded in status");

   fault_info_a: assert property (@(posedge mclk) disable iff (!rstn) // RQ2
      (acc_req && acc_unit == 4'h3 && !unit_en_reg[3]) |=> fault_unit_reg == 4'h3)
      else $error("faulted unit index not recorded");
endmodule : pcg_top

/* tb/tb_top.sv */
// self-checking bench for the group one peripheral clock gating block
// assumes pcg_pkg and pcg_top compiled before it, one clock mclk
`timescale 1ns/1ns
module tb_top;
   // ------------------------------------------------------------------
   // signals and instance
   // ------------------------------------------------------------------
   logic                        mclk;
   logic                        rstn;
   logic [11:0]                 addr;
   logic [31:0]                 wdata;
   logic                        wr;
   logic                        rd;
   logic [31:0]                 rdata_reg;
   logic                        acc_req;
   logic [3:0]                  acc_unit;
   logic                        acc_fault_reg;
   logic                        acc_ok_reg;
   logic [pcg_pkg::NUM_UNITS:0] unit_en_reg;
   logic [pcg_pkg::NUM_UNITS:0] unit_gclk;
   logic                        irq_reg;
   int                          n_fail;
   int                          cmp_count;
   int                          gate_pos [8] = '{0, 1, 4, 12, 16, 17, 18, 24};

   pcg_top uut (
      .mclk          (mclk),
      .rstn          (rstn),
      .addr          (addr),
      .wdata         (wdata),
      .wr            (wr),
      .rd            (rd),
      .rdata_reg     (rdata_reg),
      .acc_req       (acc_req),
      .acc_unit      (acc_unit),
      .acc_fault_reg (acc_fault_reg),
      .acc_ok_reg    (acc_ok_reg),
      .unit_en_reg   (unit_en_reg),
      .unit_gclk     (unit_gclk),
      .irq_reg       (irq_reg)
   );

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // ------------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------------
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr    <= 1'b0;
   endtask : reg_wr

   task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd   <= 1'b0;
      #1;
      chk(what, exp, rdata_reg);
   endtask : rd_chk

   // unit index order: async0, async1, sync0, two-wire0, counters 0-2, comparator0, watchdog
   function automatic logic [31:0] exp_en(input logic [31:0] g, input logic wd);
      return {22'h0, 1'b0, wd, g[24], g[18], g[17], g[16], g[12], g[4], g[1], g[0]};
   endfunction : exp_en

   // gclk sampled mid high phase and mid low phase: only a clean copy passes both
   task automatic en_chk(input logic [31:0] exp);
      repeat (2) @(posedge mclk);
      #1;
      chk("unit_en_reg", exp, {22'h0, unit_en_reg});
      @(posedge mclk);
      #2;
      chk("unit_gclk high", exp, {22'h0, unit_gclk});
      @(negedge mclk);
      #2;
      chk("unit_gclk low", 32'h0, {22'h0, unit_gclk});
   endtask : en_chk

   task automatic access(input logic [3:0] u, input logic flt);
      @(posedge mclk);
      acc_req  <= 1'b1;
      acc_unit <= u;
      @(posedge mclk);
      acc_req  <= 1'b0;
      #1;
      chk("acc_fault_reg", {31'h0, flt}, {31'h0, acc_fault_reg});
      chk("acc_ok_reg", {31'h0, ~flt}, {31'h0, acc_ok_reg});
   endtask : access

   task automatic irq_chk(input logic exp);
      repeat (2) @(posedge mclk);
      #1;
      chk("irq_reg", {31'h0, exp}, {31'h0, irq_reg});
   endtask : irq_chk

   task automatic do_reset;
      @(posedge mclk);
      rstn <= 1'b0;
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
   endtask : do_reset

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      rstn      = 1'b0;
      addr      = 12'h000;
      wdata     = 32'h0000_0000;
      wr        = 1'b0;
      rd        = 1'b0;
      acc_req   = 1'b0;
      acc_unit  = 4'h0;
      n_fail    = 0;
      cmp_count = 0;
      do_reset();
      rd_chk("run gate", pcg_pkg::RUN_GATE_OFS, 32'h0000_0000);
      rd_chk("sleep gate", pcg_pkg::SLEEP_GATE_OFS, 32'h0000_0000);
      rd_chk("deep gate", pcg_pkg::DEEP_GATE_OFS, 32'h0000_0000);
      rd_chk("wdog gate", pcg_pkg::WDOG_GATE_OFS, 32'h0000_0000);
      rd_chk("mode", pcg_pkg::MODE_CTRL_OFS, 32'h0000_0000);
      rd_chk("irq mask", pcg_pkg::IRQ_MASK_OFS, 32'h0000_0000);
      en_chk(exp_en(32'h0, 1'b1));
      // interrupt raise, clear, unmapped access, then masked
      reg_wr(pcg_pkg::IRQ_MASK_OFS, 32'h0000_0003);
      access(4'h3, 1'b1);
      rd_chk("fault unit", pcg_pkg::FAULT_INFO_OFS, 32'h0000_0003);
      rd_chk("irq status", pcg_pkg::IRQ_STAT_OFS, 32'h0000_0001);
      irq_chk(1'b1);
      reg_wr(pcg_pkg::IRQ_STAT_OFS, 32'h0000_0001);
      irq_chk(1'b0);
      rd_chk("unmapped", 12'h300, 32'h0000_0000);
      rd_chk("irq status", pcg_pkg::IRQ_STAT_OFS, 32'h0000_0002);
      irq_chk(1'b1);
      reg_wr(pcg_pkg::IRQ_MASK_OFS, 32'h0000_0000);
      reg_wr(pcg_pkg::IRQ_STAT_OFS, 32'h0000_0002);
      access(4'h5, 1'b1);
      irq_chk(1'b0);
      reg_wr(pcg_pkg::IRQ_STAT_OFS, 32'h0000_0003);
      // one gate bit at a time: its unit runs, its neighbour faults
      foreach (gate_pos[i]) begin
         reg_wr(pcg_pkg::RUN_GATE_OFS, 32'h1 << gate_pos[i]);
         en_chk(exp_en(32'h1 << gate_pos[i], 1'b1));
         access(4'(i), 1'b0);
         access(4'((i + 1) % 8), 1'b1);
         rd_chk("fault unit", pcg_pkg::FAULT_INFO_OFS, 32'((i + 1) % 8));
      end
      access(4'h9, 1'b1);
      access(4'h8, 1'b0);
      reg_wr(pcg_pkg::RUN_GATE_OFS, 32'hFFFF_FFFF);
      rd_chk("run gate", pcg_pkg::RUN_GATE_OFS, 32'h0107_1013);
      en_chk(exp_en(32'h0107_1013, 1'b1));
      // sleep and deep gates, with and without auto gating
      reg_wr(pcg_pkg::SLEEP_GATE_OFS, 32'hFFFE_FFEF);
      rd_chk("sleep gate", pcg_pkg::SLEEP_GATE_OFS, 32'h0106_1003);
      reg_wr(pcg_pkg::SLEEP_GATE_OFS, 32'h0001_0010);
      reg_wr(pcg_pkg::MODE_CTRL_OFS, 32'h0000_0002);
      en_chk(exp_en(32'h0107_1013, 1'b1));
      reg_wr(pcg_pkg::MODE_CTRL_OFS, 32'h0000_0003);
      en_chk(exp_en(32'h0001_0010, 1'b1));
      access(4'h2, 1'b0);
      access(4'h0, 1'b1);
      reg_wr(pcg_pkg::DEEP_GATE_OFS, 32'hFFFF_FFFF);
      rd_chk("deep gate", pcg_pkg::DEEP_GATE_OFS, 32'h0107_1013);
      reg_wr(pcg_pkg::WDOG_GATE_OFS, 32'hFFFF_FFFF);
      rd_chk("wdog gate", pcg_pkg::WDOG_GATE_OFS, 32'h0000_0008);
      reg_wr(pcg_pkg::DEEP_GATE_OFS, 32'h0100_0002);
      reg_wr(pcg_pkg::WDOG_GATE_OFS, 32'h0000_0000);
      reg_wr(pcg_pkg::MODE_CTRL_OFS, 32'h0000_0007);
      en_chk(exp_en(32'h0100_0002, 1'b0));
      access(4'h8, 1'b1);
      access(4'h7, 1'b0);
      reg_wr(pcg_pkg::WDOG_GATE_OFS, 32'h0000_0008);
      en_chk(exp_en(32'h0100_0002, 1'b1));
      reg_wr(pcg_pkg::MODE_CTRL_OFS, 32'h0000_0004);
      en_chk(exp_en(32'h0107_1013, 1'b1));
      // reset in mid-run returns every gate to zero, all units off but the watchdog
      do_reset();
      rd_chk("run gate", pcg_pkg::RUN_GATE_OFS, 32'h0000_0000);
      rd_chk("sleep gate", pcg_pkg::SLEEP_GATE_OFS, 32'h0000_0000);
      en_chk(exp_en(32'h0, 1'b1));
      access(4'h4, 1'b1);
      end_sim();
   end

   // hang guard: the whole run is well below this bound
   initial begin
      #200000;
      n_fail++;
      end_sim();
   end
endmodule : tb_top
